// ===== include/edge_hold_pkg.sv
// Shared constants and types for the edge, hold, counter and timer logic cell
package edge_hold_pkg;
    // ========================================
    // Widths
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int SEL_W = 8;
    // ========================================
    // Selection codes
    localparam logic [7:0] SEL_RISE = 8'h46;
    localparam logic [7:0] SEL_RISE_OFFD = 8'h48;
    localparam logic [7:0] SEL_RISE_ONE = 8'h49;
    localparam logic [7:0] SEL_FALL = 8'h50;
    localparam logic [7:0] SEL_FALL_OFFD = 8'h52;
    localparam logic [7:0] SEL_FALL_ONE = 8'h53;
    localparam logic [7:0] SEL_BOTH = 8'h5a;
    localparam logic [7:0] SEL_BOTH_OFFD = 8'h5c;
    localparam logic [7:0] SEL_BOTH_ONE = 8'h5d;
    localparam logic [7:0] SEL_HOLD = 8'h64;
    localparam logic [7:0] SEL_HOLD_ON = 8'h65;
    localparam logic [7:0] SEL_HOLD_OFF = 8'h66;
    localparam logic [7:0] SEL_HOLD_ONE = 8'h67;
    localparam logic [7:0] SEL_HOLD_RETRIG = 8'h68;
    localparam logic [7:0] SEL_HOLD_TRAIN = 8'h69;
    localparam logic [7:0] SEL_UP = 8'h6e;
    localparam logic [7:0] SEL_DOWN = 8'h78;
    localparam logic [7:0] SEL_TIMER = 8'h82;
    // ========================================
    // Register addresses
    localparam logic [2:0] REG_SEL = 3'h0;
    localparam logic [2:0] REG_PERIOD = 3'h1;
    localparam logic [2:0] REG_TARGET = 3'h2;
    localparam logic [2:0] REG_START = 3'h3;
    localparam logic [2:0] REG_COUNT = 3'h4;
    localparam logic [2:0] REG_STATUS = 3'h5;
    // ========================================
    // Reset values and status bits
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [15:0] PERIOD_RST = 16'h000a;
    localparam logic [15:0] TARGET_RST = 16'h000a;
    localparam logic [15:0] START_RST = 16'h000a;
    localparam int STAT_OUT_BIT = 0;
    localparam int STAT_HELD_BIT = 1;
    localparam int STAT_SUPP_BIT = 2;
    // ========================================
    // Timing
    localparam int CLK_MHZ = 20;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int EDGE_PULSE_MS = 5;
    localparam logic [15:0] EDGE_PULSE_TICKS = 16'(EDGE_PULSE_MS * 1000 / TICK_US);
    // ========================================
    // Timer stage behaviours
    typedef enum logic [5:0] {
        STG_THRU = 6'h01,
        STG_ON_DLY = 6'h02,
        STG_OFF_DLY = 6'h04,
        STG_ONE = 6'h08,
        STG_RETRIG = 6'h10,
        STG_TRAIN = 6'h20
    } stage_mode_type;
endpackage

// ===== hw/tick_base.sv
// Free running time base that pulses once per tick period
`timescale 1ns/1ns
module tick_base #(
    parameter int CYCLES = 20000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    // Tick
    output logic tick
);
    localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic tick_ff;
    logic nxt_tick;

    if (CYCLES < 2) begin : g_chk
        $error("tick_base needs at least two cycles per tick");
    end

    always_comb begin
        nxt_cnt = (cnt_ff == LAST) ? '0 : cnt_ff + CW'(1);
        nxt_tick = (cnt_ff == LAST);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else if (en) begin
            cnt_ff <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff & en;

    property p_tick_gap;
        @(posedge clk) disable iff (!nrst || !en) tick |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick lasted two cycles");
endmodule

// ===== hw/timer_stage.sv
// Timer stage: through, on-delay, off-delay, one-shot, restartable pulse, pulse train
`timescale 1ns/1ns
module timer_stage #(
    parameter int PERIOD_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    // Control
    input wire logic tick,
    input wire logic clear,
    input wire edge_hold_pkg::stage_mode_type mode,
    input wire logic [PERIOD_W-1:0] period,
    // Data
    input wire logic din,
    output logic dout
);
    logic [PERIOD_W-1:0] cnt_ff, nxt_cnt;
    logic q_ff, nxt_q, prev_ff, nxt_prev, phase_ff, nxt_phase;
    logic rise, reached, step;

    if (PERIOD_W < 1) begin : g_chk
        $error("timer_stage period width must be positive");
    end

    always_comb begin
        rise = din & ~prev_ff;
        reached = (cnt_ff >= period);
        step = tick & ~reached;
        nxt_prev = din;
        nxt_cnt = step ? cnt_ff + PERIOD_W'(1) : cnt_ff;
        nxt_q = q_ff;
        nxt_phase = phase_ff;
        case (mode)
            edge_hold_pkg::STG_THRU: begin
                nxt_q = din;
                nxt_cnt = '0;
            end
            edge_hold_pkg::STG_ON_DLY: begin
                nxt_q = din & reached;
                if (!din) nxt_cnt = '0;
            end
            edge_hold_pkg::STG_OFF_DLY: begin
                if (din) begin
                    nxt_q = 1'b1;
                    nxt_cnt = '0;
                end else if (!q_ff) begin
                    nxt_cnt = '0;
                end else if (reached) begin
                    nxt_q = 1'b0;
                end
            end
            edge_hold_pkg::STG_ONE, edge_hold_pkg::STG_RETRIG: begin
                if (rise && (!q_ff || mode == edge_hold_pkg::STG_RETRIG)) begin
                    nxt_q = 1'b1;
                    nxt_cnt = '0;
                end else if (q_ff && reached) begin
                    nxt_q = 1'b0;
                end
            end
            edge_hold_pkg::STG_TRAIN: begin
                if (!din) begin
                    nxt_phase = 1'b0;
                    nxt_cnt = '0;
                end else if (reached) begin
                    nxt_phase = ~phase_ff;
                    nxt_cnt = '0;
                end
                nxt_q = din & ~nxt_phase;
            end
            default: begin
                nxt_q = 1'b0;
                nxt_cnt = '0;
            end
        endcase
        if (clear) begin
            nxt_q = 1'b0;
            nxt_cnt = '0;
            nxt_phase = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_ff <= '0;
            q_ff <= 1'b0;
            prev_ff <= 1'b0;
            phase_ff <= 1'b0;
        end else if (en) begin
            cnt_ff <= nxt_cnt;
            q_ff <= nxt_q;
            prev_ff <= nxt_prev;
            phase_ff <= nxt_phase;
        end
    end

    assign dout = q_ff;

    property p_retrig;
        @(posedge clk) disable iff (!nrst || !en)
            (mode == edge_hold_pkg::STG_RETRIG && rise && !clear) |=> (q_ff && cnt_ff == '0);
    endproperty
    a_retrig: assert property (p_retrig) else $error("restartable pulse did not restart");

    property p_on_dly_drop;
        @(posedge clk) disable iff (!nrst || !en)
            (mode == edge_hold_pkg::STG_ON_DLY && !din) |=> !q_ff;
    endproperty
    a_on_dly_drop: assert property (p_on_dly_drop) else $error("on-delay output stayed on");
endmodule

// ===== hw/edge_hold_count_logic_cell.sv
// Configurable logic cell: edge detectors, hold, counters and resettable timer
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module edge_hold_count_logic_cell #(
    parameter int TICK_CYCLES = edge_hold_pkg::TICK_CYCLES,
    parameter int COUNT_W = 16
) (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic nrst,
    input wire logic en,
    // Register port
    input wire logic [edge_hold_pkg::ADDR_W-1:0] addr,
    input wire logic [edge_hold_pkg::DATA_W-1:0] wr_data,
    input wire logic wr,
    input wire logic rd,
    output logic [edge_hold_pkg::DATA_W-1:0] rd_data,
    // Cell inputs
    input wire logic data_in,
    input wire logic hold_in,
    input wire logic count_in,
    input wire logic reset_in,
    // Cell output
    output logic cell_out
);
    localparam int DW = edge_hold_pkg::DATA_W;
    localparam logic [COUNT_W-1:0] CNT_MAX = '1;

    if (COUNT_W < 1 || COUNT_W > DW) begin : g_chk
        $error("count width must lie between 1 and the data width");
    end

    // ========================================
    // Registers
    logic [edge_hold_pkg::SEL_W-1:0] sel_ff, nxt_sel;
    logic [DW-1:0] period_ff, nxt_period;
    logic [COUNT_W-1:0] target_ff, nxt_target;
    logic [COUNT_W-1:0] start_ff, nxt_start;
    logic [DW-1:0] rd_data_ff, nxt_rd_data;

    // ========================================
    // Cell state
    logic data_prev_ff, nxt_data_prev;
    logic count_prev_ff, nxt_count_prev;
    logic held_ff, nxt_held;
    logic [COUNT_W-1:0] count_ff, nxt_count;
    logic cell_out_ff, nxt_cell_out;

    // ========================================
    // Decode
    logic tick;
    logic rise_ev, fall_ev, cnt_rise, hold_val;
    logic supported, is_up, is_down, is_timer;
    logic stg_in, stg_clear, stg_q;
    logic [DW-1:0] stg_period;
    edge_hold_pkg::stage_mode_type stg_mode;

    tick_base #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .nrst(nrst),
        .en(en),
        .tick(tick)
    );

    always_comb begin
        rise_ev = data_in & ~data_prev_ff;
        fall_ev = ~data_in & data_prev_ff;
        cnt_rise = count_in & ~count_prev_ff;
        hold_val = hold_in ? held_ff : data_in;
        is_up = (sel_ff == edge_hold_pkg::SEL_UP);
        is_down = (sel_ff == edge_hold_pkg::SEL_DOWN);
        is_timer = (sel_ff == edge_hold_pkg::SEL_TIMER);
        supported = 1'b1;
        stg_mode = edge_hold_pkg::STG_THRU;
        stg_in = 1'b0;
        stg_period = period_ff;
        case (sel_ff)
            edge_hold_pkg::SEL_RISE: begin
                stg_mode = edge_hold_pkg::STG_RETRIG;
                stg_in = rise_ev;
                stg_period = edge_hold_pkg::EDGE_PULSE_TICKS;
            end
            edge_hold_pkg::SEL_FALL: begin
                stg_mode = edge_hold_pkg::STG_RETRIG;
                stg_in = fall_ev;
                stg_period = edge_hold_pkg::EDGE_PULSE_TICKS;
            end
            edge_hold_pkg::SEL_BOTH: begin
                stg_mode = edge_hold_pkg::STG_RETRIG;
                stg_in = rise_ev | fall_ev;
                stg_period = edge_hold_pkg::EDGE_PULSE_TICKS;
            end
            edge_hold_pkg::SEL_RISE_OFFD: begin
                stg_mode = edge_hold_pkg::STG_OFF_DLY;
                stg_in = rise_ev;
            end
            edge_hold_pkg::SEL_FALL_OFFD: begin
                stg_mode = edge_hold_pkg::STG_OFF_DLY;
                stg_in = fall_ev;
            end
            edge_hold_pkg::SEL_BOTH_OFFD: begin
                stg_mode = edge_hold_pkg::STG_OFF_DLY;
                stg_in = rise_ev | fall_ev;
            end
            edge_hold_pkg::SEL_RISE_ONE: begin
                stg_mode = edge_hold_pkg::STG_ONE;
                stg_in = rise_ev;
            end
            edge_hold_pkg::SEL_FALL_ONE: begin
                stg_mode = edge_hold_pkg::STG_ONE;
                stg_in = fall_ev;
            end
            edge_hold_pkg::SEL_BOTH_ONE: begin
                stg_mode = edge_hold_pkg::STG_ONE;
                stg_in = rise_ev | fall_ev;
            end
            edge_hold_pkg::SEL_HOLD: begin
                stg_mode = edge_hold_pkg::STG_THRU;
                stg_in = hold_val;
            end
            edge_hold_pkg::SEL_HOLD_ON: begin
                stg_mode = edge_hold_pkg::STG_ON_DLY;
                stg_in = hold_val;
            end
            edge_hold_pkg::SEL_HOLD_OFF: begin
                stg_mode = edge_hold_pkg::STG_OFF_DLY;
                stg_in = hold_val;
            end
            edge_hold_pkg::SEL_HOLD_ONE: begin
                stg_mode = edge_hold_pkg::STG_ONE;
                stg_in = hold_val;
            end
            edge_hold_pkg::SEL_HOLD_RETRIG: begin
                stg_mode = edge_hold_pkg::STG_RETRIG;
                stg_in = hold_val;
            end
            edge_hold_pkg::SEL_HOLD_TRAIN: begin
                stg_mode = edge_hold_pkg::STG_TRAIN;
                stg_in = hold_val;
            end
            edge_hold_pkg::SEL_TIMER: begin
                stg_mode = edge_hold_pkg::STG_ONE;
                stg_in = data_in;
            end
            edge_hold_pkg::SEL_UP, edge_hold_pkg::SEL_DOWN: begin
                stg_mode = edge_hold_pkg::STG_THRU;
            end
            default: begin
                supported = 1'b0;
            end
        endcase
        stg_clear = ~supported | is_up | is_down | (is_timer & reset_in);
    end

    timer_stage #(
        .PERIOD_W(DW)
    ) u_stage (
        .clk(clk),
        .nrst(nrst),
        .en(en),
        .tick(tick),
        .clear(stg_clear),
        .mode(stg_mode),
        .period(stg_period),
        .din(stg_in),
        .dout(stg_q)
    );

    // ========================================
    // Cell next state
    always_comb begin
        nxt_data_prev = data_in;
        nxt_count_prev = count_in;
        nxt_held = hold_in ? held_ff : data_in;
        nxt_count = '0;
        if (is_up) begin
            if (reset_in) begin
                nxt_count = '0;
            end else if (cnt_rise && count_ff != CNT_MAX) begin
                nxt_count = count_ff + COUNT_W'(1);
            end else begin
                nxt_count = count_ff;
            end
        end else if (is_down) begin
            if (reset_in) begin
                nxt_count = start_ff;
            end else if (cnt_rise && count_ff != '0) begin
                nxt_count = count_ff - COUNT_W'(1);
            end else begin
                nxt_count = count_ff;
            end
        end
        if (is_up) begin
            nxt_cell_out = (count_ff >= target_ff);
        end else if (is_down) begin
            nxt_cell_out = (count_ff == '0);
        end else begin
            nxt_cell_out = supported & stg_q;
        end
    end

    // ========================================
    // Register port next state
    always_comb begin
        nxt_sel = sel_ff;
        nxt_period = period_ff;
        nxt_target = target_ff;
        nxt_start = start_ff;
        nxt_rd_data = '0;
        if (wr) begin
            case (addr)
                edge_hold_pkg::REG_SEL: nxt_sel = wr_data[edge_hold_pkg::SEL_W-1:0];
                edge_hold_pkg::REG_PERIOD: nxt_period = wr_data;
                edge_hold_pkg::REG_TARGET: nxt_target = wr_data[COUNT_W-1:0];
                edge_hold_pkg::REG_START: nxt_start = wr_data[COUNT_W-1:0];
                default: nxt_sel = sel_ff;
            endcase
        end
        if (rd) begin
            case (addr)
                edge_hold_pkg::REG_SEL: nxt_rd_data = DW'(sel_ff);
                edge_hold_pkg::REG_PERIOD: nxt_rd_data = period_ff;
                edge_hold_pkg::REG_TARGET: nxt_rd_data = DW'(target_ff);
                edge_hold_pkg::REG_START: nxt_rd_data = DW'(start_ff);
                edge_hold_pkg::REG_COUNT: nxt_rd_data = DW'(count_ff);
                edge_hold_pkg::REG_STATUS: begin
                    nxt_rd_data[edge_hold_pkg::STAT_OUT_BIT] = cell_out_ff;
                    nxt_rd_data[edge_hold_pkg::STAT_HELD_BIT] = held_ff;
                    nxt_rd_data[edge_hold_pkg::STAT_SUPP_BIT] = supported;
                end
                default: nxt_rd_data = '0;
            endcase
        end
    end

    // ========================================
    // Flip-flops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_ff <= edge_hold_pkg::SEL_RST;
            period_ff <= edge_hold_pkg::PERIOD_RST;
            target_ff <= COUNT_W'(edge_hold_pkg::TARGET_RST);
            start_ff <= COUNT_W'(edge_hold_pkg::START_RST);
            rd_data_ff <= '0;
            data_prev_ff <= 1'b0;
            count_prev_ff <= 1'b0;
            held_ff <= 1'b0;
            count_ff <= '0;
            cell_out_ff <= 1'b0;
        end else if (en) begin
            sel_ff <= nxt_sel;
            period_ff <= nxt_period;
            target_ff <= nxt_target;
            start_ff <= nxt_start;
            rd_data_ff <= nxt_rd_data;
            data_prev_ff <= nxt_data_prev;
            count_prev_ff <= nxt_count_prev;
            held_ff <= nxt_held;
            count_ff <= nxt_count;
            cell_out_ff <= nxt_cell_out;
        end
    end

    assign rd_data = rd_data_ff;
    assign cell_out = cell_out_ff;

    // ========================================
    // Checks
    property p_rise_on;
        @(posedge clk) disable iff (!nrst || !en)
            (sel_ff == edge_hold_pkg::SEL_RISE && rise_ev && !wr) |-> ##2 cell_out_ff;
    endproperty
    a_rise_on: assert property (p_rise_on) else $error("rising edge gave no pulse");

    property p_up_inc;
        @(posedge clk) disable iff (!nrst || !en)
            (is_up && cnt_rise && !reset_in && count_ff != CNT_MAX && !wr)
            |=> count_ff == $past(count_ff) + COUNT_W'(1);
    endproperty
    a_up_inc: assert property (p_up_inc) else $error("up count did not step by one");

    property p_up_hit;
        @(posedge clk) disable iff (!nrst || !en)
            (is_up && count_ff >= target_ff) |=> cell_out_ff;
    endproperty
    a_up_hit: assert property (p_up_hit) else $error("target reached but output off");

    property p_up_rst;
        @(posedge clk) disable iff (!nrst || !en)
            (is_up && reset_in && !wr) |=> count_ff == '0;
    endproperty
    a_up_rst: assert property (p_up_rst) else $error("up reset did not clear");

    property p_down_dec;
        @(posedge clk) disable iff (!nrst || !en)
            (is_down && cnt_rise && !reset_in && count_ff != '0 && !wr)
            |=> count_ff == $past(count_ff) - COUNT_W'(1);
    endproperty
    a_down_dec: assert property (p_down_dec) else $error("down count did not step by one");

    property p_down_hit;
        @(posedge clk) disable iff (!nrst || !en)
            (is_down && count_ff == '0) |=> cell_out_ff;
    endproperty
    a_down_hit: assert property (p_down_hit) else $error("zero reached but output off");

    property p_down_rst;
        @(posedge clk) disable iff (!nrst || !en)
            (is_down && reset_in && !wr) |=> count_ff == $past(start_ff);
    endproperty
    a_down_rst: assert property (p_down_rst) else $error("down reset did not reload");

    property p_hold;
        @(posedge clk) disable iff (!nrst || !en)
            (sel_ff == edge_hold_pkg::SEL_HOLD && hold_in && !wr) |-> ##2 cell_out_ff == $past(held_ff, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("held value not shown");

    property p_timer_rst;
        @(posedge clk) disable iff (!nrst || !en)
            (is_timer && reset_in && !wr) |-> ##2 !cell_out_ff;
    endproperty
    a_timer_rst: assert property (p_timer_rst) else $error("timer reset left output on");

    property p_unsup;
        @(posedge clk) disable iff (!nrst || !en)
            (!supported && !wr) |=> (!cell_out_ff && count_ff == '0);
    endproperty
    a_unsup: assert property (p_unsup) else $error("unknown code left output or count");
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the edge, hold, counter and timer logic cell
`timescale 1ns/1ns
`define CHK(n, e, s) begin \
    check_count++; \
    if ((s) !== (e)) begin \
        err_count++; \
        $display("mismatch %s exp %h got %h", n, e, s); \
    end \
end
module tb_top;
    // ========================================
    // Stimulus and observation
    logic clk = 0, nrst = 0, en = 1, wr = 0, rd = 0, cell_out;
    logic data_in = 0, hold_in = 0, count_in = 0, reset_in = 0, b;
    logic [2:0] addr = 3'h0;
    logic [15:0] wr_data = 16'h0000, rd_data, v;
    logic [7:0] ec [9] = '{8'h46, 8'h48, 8'h49, 8'h50, 8'h52, 8'h53, 8'h5a, 8'h5c, 8'h5d};
    logic [8:0] el = 9'b111000111;
    logic [15:0] rv [8] = '{16'h0000, 16'h000a, 16'h000a, 16'h000a, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    int err_count = 0, check_count = 0, n, t;
    always #25 clk = ~clk;
    edge_hold_count_logic_cell #(.TICK_CYCLES(4)) edge_hold_count_logic_cell_inst (.clk(clk), .nrst(nrst),
        .en(en), .addr(addr), .wr_data(wr_data), .wr(wr), .rd(rd), .rd_data(rd_data), .data_in(data_in),
        .hold_in(hold_in), .count_in(count_in), .reset_in(reset_in), .cell_out(cell_out));
    // ========================================
    // Bus and pin tasks
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wreg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        v = rd_data;
    endtask
    task automatic cnt_pulse();
        @(posedge clk);
        count_in <= 1'b1;
        @(posedge clk);
        count_in <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rst_pulse();
        @(posedge clk);
        reset_in <= 1'b1;
        @(posedge clk);
        reset_in <= 1'b0;
    endtask
    function automatic logic [15:0] down_status(input logic hit);
        return {13'h0000, 1'b1, 1'b0, hit};
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #5000000;
        err_count++;
        give_verdict();
    end
    // ========================================
    // Main sequence
    initial begin
        n = $urandom(32'hfc93);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rreg(3'(a));
            `CHK("reset reg", rv[a], v)
        end
        $display("register reset test done");
        wreg(3'h1, 16'h0003);
        rreg(3'h1);
        `CHK("period", 16'h0003, v)
        for (int i = 0; i < 9; i++) begin
            wreg(3'h0, {8'h00, ec[i]});
            @(posedge clk);
            data_in <= ~el[i];
            cyc(40);
            @(posedge clk);
            data_in <= el[i];
            cyc(4);
            `CHK("edge on", 1'b1, cell_out)
            cyc(40);
            `CHK("edge off", 1'b0, cell_out)
        end
        $display("edge test done");
        wreg(3'h0, 16'h0064);
        repeat (4) begin
            b = 1'($urandom);
            @(posedge clk);
            data_in <= b;
            cyc(4);
            `CHK("hold pass", b, cell_out)
            @(posedge clk);
            hold_in <= 1'b1;
            cyc(2);
            @(posedge clk);
            data_in <= ~b;
            cyc(4);
            `CHK("hold keep", b, cell_out)
            @(posedge clk);
            hold_in <= 1'b0;
        end
        wreg(3'h0, 16'h0065);
        data_in <= 1'b0;
        cyc(20);
        @(posedge clk);
        data_in <= 1'b1;
        cyc(4);
        `CHK("ondly early", 1'b0, cell_out)
        cyc(16);
        `CHK("ondly late", 1'b1, cell_out)
        @(posedge clk);
        data_in <= 1'b0;
        cyc(4);
        `CHK("ondly drop", 1'b0, cell_out)
        wreg(3'h0, 16'h0066);
        @(posedge clk);
        data_in <= 1'b1;
        cyc(4);
        `CHK("offdly on", 1'b1, cell_out)
        @(posedge clk);
        data_in <= 1'b0;
        cyc(4);
        `CHK("offdly stretch", 1'b1, cell_out)
        cyc(20);
        `CHK("offdly end", 1'b0, cell_out)
        wreg(3'h0, 16'h0067);
        @(posedge clk);
        data_in <= 1'b1;
        cyc(4);
        `CHK("one on", 1'b1, cell_out)
        cyc(20);
        `CHK("one end", 1'b0, cell_out)
        wreg(3'h0, 16'h0068);
        @(posedge clk);
        data_in <= 1'b0;
        @(posedge clk);
        data_in <= 1'b1;
        cyc(6);
        @(posedge clk);
        data_in <= 1'b0;
        @(posedge clk);
        data_in <= 1'b1;
        cyc(8);
        `CHK("retrig keep", 1'b1, cell_out)
        cyc(20);
        `CHK("retrig end", 1'b0, cell_out)
        wreg(3'h0, 16'h0069);
        @(posedge clk);
        data_in <= 1'b0;
        cyc(2);
        @(posedge clk);
        data_in <= 1'b1;
        t = 0;
        repeat (60) begin
            cyc(1);
            t += int'(cell_out);
        end
        `CHK("train mix", 1'b1, t > 5 && t < 55)
        @(posedge clk);
        data_in <= 1'b0;
        $display("hold test done");
        wreg(3'h0, 16'h006e);
        repeat (2) begin
            t = $urandom_range(6, 2);
            wreg(3'h2, 16'(t));
            rst_pulse();
            n = $urandom_range(8, 1);
            repeat (n) cnt_pulse();
            rreg(3'h4);
            `CHK("up count", 16'(n), v)
            `CHK("up out", n >= t, cell_out)
            rst_pulse();
            rreg(3'h4);
            `CHK("up reset", 16'h0000, v)
        end
        @(posedge clk);
        en <= 1'b0;
        cnt_pulse();
        @(posedge clk);
        en <= 1'b1;
        rreg(3'h4);
        `CHK("freeze count", 16'h0000, v)
        wreg(3'h0, 16'h0078);
        repeat (2) begin
            t = $urandom_range(8, 3);
            wreg(3'h3, 16'(t));
            rst_pulse();
            rreg(3'h4);
            `CHK("down load", 16'(t), v)
            n = $urandom_range(t, 1);
            repeat (n) cnt_pulse();
            rreg(3'h4);
            `CHK("down count", 16'(t - n), v)
            `CHK("down out", n == t, cell_out)
            rreg(3'h5);
            `CHK("down status", down_status(n == t), v)
        end
        $display("counter test done");
        wreg(3'h0, 16'h0082);
        @(posedge clk);
        data_in <= 1'b1;
        cyc(4);
        `CHK("timer on", 1'b1, cell_out)
        cyc(16);
        `CHK("timer end", 1'b0, cell_out)
        @(posedge clk);
        data_in <= 1'b0;
        cyc(4);
        @(posedge clk);
        data_in <= 1'b1;
        cyc(4);
        @(posedge clk);
        reset_in <= 1'b1;
        cyc(3);
        `CHK("timer reset", 1'b0, cell_out)
        @(posedge clk);
        reset_in <= 1'b0;
        data_in <= 1'b0;
        $display("timer test done");
        wreg(3'h0, 16'h0001);
        cnt_pulse();
        cnt_pulse();
        rreg(3'h4);
        `CHK("bad code count", 16'h0000, v)
        `CHK("bad code out", 1'b0, cell_out)
        $display("unsupported code test done");
        give_verdict();
    end
endmodule
